/* include/synth_load_regs.vh */
// Purpose: constants for the synthesizer serial load control
// Assumes: included by bare name from the design file
// Notes: widths are plain defaults, not device figures
`ifndef SYNTH_LOAD_REGS_VH
`define SYNTH_LOAD_REGS_VH
`define SHIFT_WIDTH 19
`define CTRL_BIT_POS 0
`define CTRL_SEL_REF 1'b1
`define CTRL_SEL_DIV 1'b0
`define LOCK_PULSE_CYCLES 4
`define LOCK_PERIOD_CYCLES 256
`endif

/* tb/serial_host.sv */
// Purpose: host shifting words into the block
// Assumes: 125 ns serial clock
// Notes: clock idles low between frames
module serial_host(output logic serial_clk, serial_data, load_strobe);
  timeunit 1ns; timeprecision 100ps;
  initial {serial_clk, serial_data, load_strobe} = 3'h0;
  task automatic send(input logic [18:0] w);
    for (int i = 18; i >= 0; i--) begin
      serial_data = w[i];
      #62.5 serial_clk = 1;
      #62.5 serial_clk = 0;
    end
    #62.5 load_strobe = 1;
    #62.5 load_strobe = 0;
    serial_data = ~serial_data;
    #62.5;
  endtask
endmodule

/* tb/synth_serial_load_control_props.sv */
// Purpose: port checks for serial load control
// Assumes: sync lag under four cycles
// Notes: pull-ups folded into effective levels
module synth_props(input wire sys_clk, resetn, load_strobe, load_strobe_driven,
  phase_polarity_select, phase_polarity_driven, pump_up, pump_down, pump_up_out,
  pump_down_out, loop_bypass_switch_out, lock_indicator, loop_locked,
  input wire [17:0] ref_latch, div_latch);
  timeunit 1ns; timeprecision 100ps;
  wire le = load_strobe | !load_strobe_driven;
  wire pn = phase_polarity_select | !phase_polarity_driven;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Strobe syncs restart high after reset, so wait until they are flushed
  chk_bypass_on: assert property (le[*5] ##0 $past(resetn, 4) |-> loop_bypass_switch_out)
    else $error("sw");
  chk_bypass_off: assert property (!le[*5] ##0 $past(resetn, 4) |-> !loop_bypass_switch_out)
    else $error("so");
  chk_pol_norm: assert property (pn[*4] ##0 $past(resetn, 4) |-> pump_up_out == $past(pump_up))
    else $error("pn");
  chk_pol_inv: assert property (!pn[*4] ##0 $past(resetn, 4) |-> pump_up_out == $past(pump_down))
    else $error("pi");
  chk_pump_down: assert property (pn[*4] ##0 $past(resetn, 4) |-> pump_down_out == $past(pump_down))
    else $error("pd");
  chk_pump_swap: assert property (!pn[*4] ##0 $past(resetn, 4) |-> pump_down_out == $past(pump_up))
    else $error("ps");
  chk_latch_hold: assert property (!le[*6] |-> $stable(ref_latch)) else $error("lh");
  chk_latch_one: assert property ($changed(ref_latch) |-> $stable(div_latch)) else $error("lo");
  chk_lock_off: assert property (!loop_locked[*4] |-> !lock_indicator) else $error("lk");
  chk_lock_pulse: assert property (loop_locked[*8] ##0 $fell(lock_indicator) |-> ##4 lock_indicator)
    else $error("lp");
  cover property ($rose(loop_bypass_switch_out));
  cover property ($fell(lock_indicator));
  cover property ($changed(div_latch));
endmodule

/* tb/tb_synth_serial_load_control.sv */
// Purpose: random words into both latches
// Assumes: host model paces frames
// Notes: pumps and polarity wander at random
module tb_synth_serial_load_control;
  timeunit 1ns; timeprecision 100ps;
  logic sys_clk = 0, resetn = 0, load_strobe_driven = 1, phase_polarity_select = 1;
  logic phase_polarity_driven = 1, loop_locked = 1, pump_up = 0, pump_down = 0;
  wire serial_clk, serial_data, load_strobe, pump_up_out, pump_down_out;
  wire loop_bypass_switch_out, lock_indicator;
  wire [17:0] ref_latch, div_latch;
  logic [31:0] r = 32'h924A, s = 32'h924A;
  logic [17:0] ref_e = 18'h0, div_e = 18'h0;
  int fail_count = 0, n_tests = 0;
  synth_serial_load_control dut(.*);
  serial_host host(.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; return x ^ (x << 5);
  endfunction
  task automatic chk(string n, logic [17:0] e, logic [17:0] v);
    n_tests++;
    if (v !== e) begin fail_count++; $display("BAD %s exp %h got %h", n, e, v); end
  endtask
  task automatic tally_and_finish;
    $display("fails %0d of %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    r = xs(r);
    pump_up <= r[0];
    pump_down <= r[1];
    if (r[9:6] == 4'h0) phase_polarity_select <= r[2];
    if (r[12:6] == 7'h0) phase_polarity_driven <= r[3];
  end
  initial begin
    #100000 fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1;
    for (int k = 0; k < 8; k++) begin
      s = xs(s);
      s[0] = k[0] ^ k[2];
      host.send(s[18:0]);
      if (s[0]) ref_e = s[18:1];
      else div_e = s[18:1];
      chk("ref", ref_e, ref_latch);
      chk("div", div_e, div_latch);
    end
    loop_locked <= 0;
    repeat (9) @(posedge sys_clk);
    chk("lock", 18'h0, {17'h0, lock_indicator});
    load_strobe_driven <= 0;
    repeat (9) @(posedge sys_clk);
    chk("bypass", 18'h1, {17'h0, loop_bypass_switch_out});
    tally_and_finish;
  end
endmodule
bind synth_serial_load_control synth_props u_props(.*);

/* verilog/synth_serial_load_control.v */
// Purpose: serial word load, latch select, polarity, bypass and lock output
// Assumes: serial pins are asynchronous to sys_clk and slower than it
// Notes: serial clock edges found by sampling; no reset pin on the real part
//
// Operation
// - Sample data on serial clock rising edge
// - Words arrive MSB first, LSB selects latch
// - Load copies shift register into selected latch
// - Load happens on strobe low-to-high transition
// - Low polarity select inverts pump sense
// - Undriven polarity select gives normal sense
// - Strobe high closes loop bypass switch
// - Locked loop gives high output, brief lows
`include "synth_load_regs.vh"
module synth_serial_load_control #(
  parameter WIDTH = `SHIFT_WIDTH,
  parameter PULSE_CYCLES = `LOCK_PULSE_CYCLES,
  parameter PERIOD_CYCLES = `LOCK_PERIOD_CYCLES
) (
  input wire sys_clk,
  input wire resetn,
  input wire serial_clk,
  input wire serial_data,
  input wire load_strobe,
  input wire load_strobe_driven,
  input wire phase_polarity_select,
  input wire phase_polarity_driven,
  input wire loop_locked,
  input wire pump_up,
  input wire pump_down,
  output reg [WIDTH-2:0] ref_latch,
  output reg [WIDTH-2:0] div_latch,
  output reg pump_up_out,
  output reg pump_down_out,
  output reg loop_bypass_switch_out,
  output reg lock_indicator
);
  reg clk_s1_reg, clk_s2_reg, clk_s3_reg;
  reg dat_s1_reg, dat_s2_reg;
  reg le_s1_reg, le_s2_reg, le_s3_reg;
  reg pol_s1_reg, pol_s2_reg;
  reg lock_s1_reg, lock_s2_reg;
  reg [WIDTH-1:0] shift_reg;
  reg [8:0] lock_cnt_reg;
  wire le_raw;
  wire pol_raw;
  wire sclk_rise;
  wire le_rise;
  wire pol_normal;

  // Pull-ups modelled: undriven pins read high
  assign le_raw = load_strobe_driven ? load_strobe : 1'b1;
  assign pol_raw = phase_polarity_driven ? phase_polarity_select : 1'b1;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      dat_s1_reg <= 1'b0;
      dat_s2_reg <= 1'b0;
      le_s1_reg <= 1'b1;
      le_s2_reg <= 1'b1;
      le_s3_reg <= 1'b1;
      pol_s1_reg <= 1'b1;
      pol_s2_reg <= 1'b1;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      clk_s1_reg <= serial_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= serial_data;
      dat_s2_reg <= dat_s1_reg;
      le_s1_reg <= le_raw;
      le_s2_reg <= le_s1_reg;
      le_s3_reg <= le_s2_reg;
      pol_s1_reg <= pol_raw;
      pol_s2_reg <= pol_s1_reg;
      lock_s1_reg <= loop_locked;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  assign sclk_rise = clk_s2_reg & ~clk_s3_reg;
  assign le_rise = le_s2_reg & ~le_s3_reg;
  assign pol_normal = pol_s2_reg;

  // Shift in, MSB first; data stays aligned with clock through equal sync depth
  always @(posedge sys_clk) begin
    if (!resetn) begin
      shift_reg <= {WIDTH{1'b0}};
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[WIDTH-2:0], dat_s2_reg};
    end
  end

  // Serial clock is low at strobe edges, so shift and load never collide
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ref_latch <= {(WIDTH-1){1'b0}};
      div_latch <= {(WIDTH-1){1'b0}};
    end else if (le_rise) begin
      if (shift_reg[`CTRL_BIT_POS] == `CTRL_SEL_REF) begin
        ref_latch <= shift_reg[WIDTH-1:1];
      end else begin
        div_latch <= shift_reg[WIDTH-1:1];
      end
    end
  end

  // Pump pair sense and bypass switch follow the synced pins
  always @(posedge sys_clk) begin
    if (!resetn) begin
      pump_up_out <= 1'b0;
      pump_down_out <= 1'b0;
      loop_bypass_switch_out <= 1'b0;
    end else begin
      pump_up_out <= pol_normal ? pump_up : pump_down;
      pump_down_out <= pol_normal ? pump_down : pump_up;
      loop_bypass_switch_out <= le_s2_reg;
    end
  end

  // Locked: high with a short low pulse once per period
  always @(posedge sys_clk) begin
    if (!resetn) begin
      lock_cnt_reg <= 9'h000;
      lock_indicator <= 1'b0;
    end else if (!lock_s2_reg) begin
      lock_cnt_reg <= 9'h000;
      lock_indicator <= 1'b0;
    end else begin
      if (lock_cnt_reg == PERIOD_CYCLES - 1) begin
        lock_cnt_reg <= 9'h000;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + 9'h001;
      end
      lock_indicator <= (lock_cnt_reg >= PULSE_CYCLES);
    end
  end
endmodule
